// ===== common/brk_pkg.sv
package brk_pkg;
	// register offsets in the device's own space
	localparam logic [15:0] OFS_WAIT_STATUS = 16'hFE00;
	localparam logic [15:0] OFS_FLAG_CLEAR = 16'hFE03;
	localparam logic [15:0] OFS_ADDR_HIGH = 16'hFE09;
	localparam logic [15:0] OFS_ADDR_LOW = 16'hFE0A;
	localparam logic [15:0] OFS_CTRL_STATUS = 16'hFE0B;
	// field positions
	localparam int BIT_BREAK_ENABLE = 7;
	localparam int BIT_BREAK_ACTIVE = 6;
	localparam int BIT_WAIT_EXIT = 1;
	localparam int BIT_FLAG_CLEAR_EN = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// break vectors used by the system integration logic
	localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
	localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
	localparam logic [7:0] OPC_SOFT_INT = 8'h83; // arbitrary opcode value
	// controller register offsets on axi4-lite
	localparam logic [3:0] AX_CMD = 4'h0;
	localparam logic [3:0] AX_STATUS = 4'h4;
	localparam logic [3:0] AX_IRQ_STAT = 4'h8;
	localparam logic [3:0] AX_IRQ_MASK = 4'hC;
	localparam int IRQ_BITS = 2;
	localparam int IRQ_BREAK = 0;
	localparam int IRQ_RETURN = 1;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : brk_pkg

// ===== common/brk_if.sv
`timescale 1ns/1ps
interface brk_if;
	logic [15:0] cpu_addr; // processor address bus
	logic addr_valid; // processor-generated address cycle
	logic opcode_fetch; // cycle is an opcode fetch
	logic insn_start; // next instruction begins this cycle
	logic reg_wr; // register write strobe
	logic reg_rd; // register read strobe
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_hit; // address decodes to a break register
	logic brk_in_service; // break routine running
	logic return_seen; // return executed in break routine
	logic in_wait; // processor is in wait mode
	logic breakpoint_request; // one-cycle request
	logic flag_clear_allow; // status clears permitted in break
	modport dev (input cpu_addr, addr_valid, opcode_fetch, insn_start, reg_wr, reg_rd,
		reg_addr, reg_wdata, brk_in_service, return_seen, in_wait,
		output reg_rdata, reg_hit, breakpoint_request, flag_clear_allow);
	modport sil (output cpu_addr, addr_valid, opcode_fetch, insn_start, reg_wr, reg_rd,
		reg_addr, reg_wdata, brk_in_service, return_seen, in_wait,
		input reg_rdata, reg_hit, breakpoint_request, flag_clear_allow);
endinterface : brk_if

// ===== verilog/brk_unit.sv
`timescale 1ns/1ps
// Functional notes
// - address match asserts breakpoint request
// - integration logic substitutes software interrupt opcode
// - vector FFFC normal, FEFC in monitor
// - writing one to active bit breaks
// - return instruction ends break state
// - opcode-address break precedes that instruction
// - operand-address break follows that instruction; this unit requests at once, as for an opcode address
// - software break taken before next instruction
// - unchanged address does not break again
// - new address plus clear repeats breaks
// - software should target opcode addresses
// - control: enable bit7, active bit6, rest zero
// - wait-exit status bit1, cleared writing zero
// - match breaks only while enable set
// - match sets active, software clears it
// - flag clears in break need clear enable
module brk_unit (
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	brk_if.dev LINK
);
	logic [15:0] bp_addr_q, bp_addr_d; // breakpoint address
	logic enable_q, enable_d; // break enable
	logic active_q, active_d; // break active
	logic wait_exit_q, wait_exit_d; // wait exited by break
	logic clr_en_q, clr_en_d; // flag clear enable
	logic pend_q, pend_d; // software break waiting for next instruction
	logic armed_q, armed_d; // match allowed to fire
	logic match;
	logic wr_active_one;

	// register decode, drives reg_hit only; read and write paths decode on their own
	function automatic logic is_reg(input logic [15:0] a);
		return a == brk_pkg::OFS_WAIT_STATUS || a == brk_pkg::OFS_FLAG_CLEAR ||
			a == brk_pkg::OFS_ADDR_HIGH || a == brk_pkg::OFS_ADDR_LOW ||
			a == brk_pkg::OFS_CTRL_STATUS;
	endfunction : is_reg

	// full 16-bit compare on processor address cycles only
	assign match = LINK.addr_valid && enable_q && armed_q &&
		LINK.cpu_addr == bp_addr_q;
	assign wr_active_one = LINK.reg_wr && LINK.reg_addr == brk_pkg::OFS_CTRL_STATUS &&
		LINK.reg_wdata[brk_pkg::BIT_BREAK_ACTIVE];

	// next state of all registers
	always_comb begin
		bp_addr_d = bp_addr_q;
		enable_d = enable_q;
		active_d = active_q;
		wait_exit_d = wait_exit_q;
		clr_en_d = clr_en_q;
		pend_d = pend_q;
		armed_d = armed_q;
		if (LINK.reg_wr) begin
			case (LINK.reg_addr)
				brk_pkg::OFS_ADDR_HIGH: begin
					bp_addr_d[15:8] = LINK.reg_wdata;
					armed_d = 1'b1; // new address rearms
				end
				brk_pkg::OFS_ADDR_LOW: begin
					bp_addr_d[7:0] = LINK.reg_wdata;
					armed_d = 1'b1;
				end
				brk_pkg::OFS_CTRL_STATUS: begin
					enable_d = LINK.reg_wdata[brk_pkg::BIT_BREAK_ENABLE];
					active_d = LINK.reg_wdata[brk_pkg::BIT_BREAK_ACTIVE];
					if (wr_active_one) begin
						pend_d = 1'b1;
					end
				end
				brk_pkg::OFS_WAIT_STATUS: begin
					// only a zero clears; a one leaves the bit alone
					if (!LINK.reg_wdata[brk_pkg::BIT_WAIT_EXIT]) begin
						wait_exit_d = 1'b0;
					end
				end
				brk_pkg::OFS_FLAG_CLEAR: begin
					clr_en_d = LINK.reg_wdata[brk_pkg::BIT_FLAG_CLEAR_EN];
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over a same-cycle clear
		if (match) begin
			active_d = 1'b1;
			armed_d = 1'b0; // same address will not refire
			if (LINK.in_wait) begin
				wait_exit_d = 1'b1;
			end
		end
		// software break fires at the next instruction boundary
		if (pend_q && LINK.insn_start) begin
			pend_d = wr_active_one;
		end
	end

	// state registers
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			bp_addr_q <= 16'h0000;
			enable_q <= 1'b0;
			active_q <= 1'b0;
			wait_exit_q <= 1'b0;
			clr_en_q <= 1'b0;
			pend_q <= 1'b0;
			armed_q <= 1'b1;
		end else begin
			bp_addr_q <= bp_addr_d;
			enable_q <= enable_d;
			active_q <= active_d;
			wait_exit_q <= wait_exit_d;
			clr_en_q <= clr_en_d;
			pend_q <= pend_d;
			armed_q <= armed_d;
		end
	end

	// request is combinational so the fetch in flight can be replaced
	assign LINK.breakpoint_request = match || (pend_q && LINK.insn_start);
	assign LINK.flag_clear_allow = !LINK.brk_in_service || clr_en_q;
	assign LINK.reg_hit = is_reg(LINK.reg_addr);

	// read mux; unimplemented bits read zero
	always_comb begin
		LINK.reg_rdata = brk_pkg::RST_BYTE;
		if (LINK.reg_rd) begin
			case (LINK.reg_addr)
				brk_pkg::OFS_ADDR_HIGH: LINK.reg_rdata = bp_addr_q[15:8];
				brk_pkg::OFS_ADDR_LOW: LINK.reg_rdata = bp_addr_q[7:0];
				brk_pkg::OFS_CTRL_STATUS: begin
					LINK.reg_rdata[brk_pkg::BIT_BREAK_ENABLE] = enable_q;
					LINK.reg_rdata[brk_pkg::BIT_BREAK_ACTIVE] = active_q;
				end
				brk_pkg::OFS_WAIT_STATUS: LINK.reg_rdata[brk_pkg::BIT_WAIT_EXIT] = wait_exit_q;
				brk_pkg::OFS_FLAG_CLEAR: LINK.reg_rdata[brk_pkg::BIT_FLAG_CLEAR_EN] = clr_en_q;
				default: LINK.reg_rdata = brk_pkg::RST_BYTE;
			endcase
		end
	end
endmodule : brk_unit

// ===== verilog/brk_sil.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// stand-in for the system integration logic, steered from axi4-lite
module brk_sil (
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	brk_if.sil LINK,
	input wire logic MONITOR_MODE_IN, // selects the monitor vector
	input wire logic [15:0] CPU_ADDR_IN,
	input wire logic CPU_ADDR_VALID_IN,
	input wire logic CPU_OPCODE_FETCH_IN,
	input wire logic CPU_INSN_START_IN,
	input wire logic CPU_RETURN_IN, // return instruction retired
	input wire logic CPU_WAIT_IN,
	input wire logic [7:0] CPU_FETCH_OPCODE_IN,
	output logic [7:0] CPU_IR_OPCODE_OUT, // opcode for instruction register
	output logic [15:0] CPU_VECTOR_OUT,
	output logic CPU_TAKE_BREAK_OUT,
	output logic IRQ_OUT,
	input wire logic [3:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [3:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN
);
	typedef enum {S_IDLE, S_WR, S_RD} brk_st_e;
	brk_st_e st_q, st_d; // register access sequencer
	logic [31:0] cmd_q, cmd_d; // [23:16] wdata, [15:0] addr, bit24 write, bit25 go
	logic [7:0] rbyte_q, rbyte_d; // last read byte
	logic svc_q, svc_d; // break routine running
	logic [1:0] ist_q, ist_d; // sticky events
	logic [1:0] imask_q, imask_d;
	logic aw_q, aw_d, w_q, w_d; // write channel captures
	logic [3:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic bv_q, bv_d, rv_q, rv_d;
	logic [31:0] rd_q, rd_d;
	logic [1:0] rr_q, rr_d, br_q, br_d;
	logic go;

	// processor signals pass through to the unit; the return passes only while the break routine runs
	assign LINK.cpu_addr = CPU_ADDR_IN;
	assign LINK.addr_valid = CPU_ADDR_VALID_IN;
	assign LINK.opcode_fetch = CPU_OPCODE_FETCH_IN;
	assign LINK.insn_start = CPU_INSN_START_IN;
	assign LINK.in_wait = CPU_WAIT_IN;
	assign LINK.brk_in_service = svc_q;
	assign LINK.return_seen = CPU_RETURN_IN && svc_q;
	assign LINK.reg_wr = (st_q == S_WR);
	assign LINK.reg_rd = (st_q == S_RD);
	assign LINK.reg_addr = cmd_q[15:0];
	assign LINK.reg_wdata = cmd_q[23:16];
	// substitute opcode on a request; the vector follows the monitor mode input alone
	// any match takes effect at once, opcode-address or operand-address alike
	assign CPU_TAKE_BREAK_OUT = LINK.breakpoint_request;
	assign CPU_IR_OPCODE_OUT = LINK.breakpoint_request ? brk_pkg::OPC_SOFT_INT
		: CPU_FETCH_OPCODE_IN;
	assign CPU_VECTOR_OUT = MONITOR_MODE_IN ? brk_pkg::VEC_MONITOR
		: brk_pkg::VEC_NORMAL;
	assign IRQ_OUT = |(ist_q & imask_q);
	assign AWREADY_OUT = !aw_q && !bv_q;
	assign WREADY_OUT = !w_q && !bv_q;
	assign ARREADY_OUT = !rv_q && st_q == S_IDLE;
	assign BVALID_OUT = bv_q;
	assign BRESP_OUT = br_q;
	assign RVALID_OUT = rv_q;
	assign RDATA_OUT = rd_q;
	assign RRESP_OUT = rr_q;
	assign go = aw_q && w_q && !bv_q;

	// axi slave, command sequencer, sticky events
	always_comb begin
		st_d = S_IDLE;
		cmd_d = cmd_q;
		rbyte_d = rbyte_q;
		svc_d = svc_q;
		ist_d = ist_q;
		imask_d = imask_q;
		aw_d = aw_q || (AWVALID_IN && AWREADY_OUT);
		w_d = w_q || (WVALID_IN && WREADY_OUT);
		awa_d = (AWVALID_IN && AWREADY_OUT) ? AWADDR_IN : awa_q;
		wd_d = (WVALID_IN && WREADY_OUT) ? WDATA_IN : wd_q;
		bv_d = bv_q && !BREADY_IN;
		br_d = br_q;
		rv_d = rv_q && !RREADY_IN;
		rd_d = rd_q;
		rr_d = rr_q;
		// sequencer runs one device access per go
		case (st_q)
			S_IDLE: st_d = S_IDLE;
			S_WR: st_d = S_IDLE;
			S_RD: begin
				st_d = S_IDLE;
				rbyte_d = LINK.reg_rdata;
			end
			default: st_d = S_IDLE;
		endcase
		if (st_q == S_IDLE && cmd_q[25]) begin
			st_d = cmd_q[24] ? S_WR : S_RD;
			cmd_d[25] = 1'b0;
		end
		if (go) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = brk_pkg::AXI_OKAY;
			case (awa_q)
				brk_pkg::AX_CMD: cmd_d = wd_q;
				brk_pkg::AX_IRQ_STAT: ist_d = ist_q & ~wd_q[1:0];
				brk_pkg::AX_IRQ_MASK: imask_d = wd_q[1:0];
				brk_pkg::AX_STATUS: br_d = brk_pkg::AXI_OKAY;
				default: br_d = brk_pkg::AXI_SLVERR;
			endcase
		end
		if (ARVALID_IN && ARREADY_OUT) begin
			rv_d = 1'b1;
			rr_d = brk_pkg::AXI_OKAY;
			case (ARADDR_IN)
				brk_pkg::AX_CMD: rd_d = cmd_q;
				brk_pkg::AX_STATUS: rd_d = {21'h000000, LINK.flag_clear_allow, svc_q,
					LINK.reg_hit, rbyte_q};
				brk_pkg::AX_IRQ_STAT: rd_d = {30'h00000000, ist_q};
				brk_pkg::AX_IRQ_MASK: rd_d = {30'h00000000, imask_q};
				default: begin
					rd_d = 32'h00000000;
					rr_d = brk_pkg::AXI_SLVERR;
				end
			endcase
		end
		// break entry and exit; set wins over clear
		if (LINK.return_seen) begin
			svc_d = 1'b0;
			ist_d[brk_pkg::IRQ_RETURN] = 1'b1;
		end
		if (LINK.breakpoint_request) begin
			svc_d = 1'b1;
			ist_d[brk_pkg::IRQ_BREAK] = 1'b1;
		end
	end

	// registers
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			st_q <= S_IDLE;
			cmd_q <= 32'h00000000;
			rbyte_q <= 8'h00;
			svc_q <= 1'b0;
			ist_q <= 2'h0;
			imask_q <= 2'h0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 4'h0;
			wd_q <= 32'h00000000;
			bv_q <= 1'b0;
			br_q <= 2'h0;
			rv_q <= 1'b0;
			rd_q <= 32'h00000000;
			rr_q <= 2'h0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			rbyte_q <= rbyte_d;
			svc_q <= svc_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
		end
	end
endmodule : brk_sil

// ===== verif/brk_checker.sv
`timescale 1ns/1ps
// watches the link between the breakpoint unit and the integration logic
module brk_checker (
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [15:0] cpu_addr,
	input wire logic addr_valid,
	input wire logic insn_start,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic brk_in_service,
	input wire logic breakpoint_request,
	input wire logic flag_clear_allow
);
	logic [15:0] bp_q; // shadow of the programmed address
	logic en_q; // shadow of the enable bit
	logic arm_q; // shadow of the one-shot arming
	logic hit_w; // enabled full address match this cycle
	assign hit_w = addr_valid && en_q && cpu_addr == bp_q;
	// shadows follow register writes, so no design internals are needed
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			bp_q <= 16'h0000;
			en_q <= 1'b0;
			arm_q <= 1'b1;
		end else if (reg_wr) begin
			// either address byte rearms the comparator
			if (reg_addr == brk_pkg::OFS_ADDR_HIGH) bp_q[15:8] <= reg_wdata;
			if (reg_addr == brk_pkg::OFS_ADDR_LOW) bp_q[7:0] <= reg_wdata;
			if (reg_addr == brk_pkg::OFS_ADDR_HIGH || reg_addr == brk_pkg::OFS_ADDR_LOW) arm_q <= 1'b1;
			if (reg_addr == brk_pkg::OFS_CTRL_STATUS) en_q <= reg_wdata[brk_pkg::BIT_BREAK_ENABLE];
		end else if (addr_valid && !insn_start && breakpoint_request) begin
			arm_q <= 1'b0; // a taken match disarms, except at an instruction start or in a register write cycle
		end
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	chk_match_exact: assert property (addr_valid && !insn_start && breakpoint_request
		|-> hit_w) else $error("request without an enabled address match");
	chk_match_fires: assert property (hit_w && arm_q |-> breakpoint_request)
		else $error("armed enabled match gave no request");
	chk_one_per_match: assert property (addr_valid && !arm_q && !insn_start
		|-> !breakpoint_request) else $error("disarmed address raised a request");
	chk_soft_start: assert property (breakpoint_request && !hit_w |-> insn_start)
		else $error("software request outside instruction start");
	chk_ctrl_read: assert property (reg_rd && reg_addr == brk_pkg::OFS_CTRL_STATUS
		|-> reg_rdata[5:0] == 6'h00 && reg_rdata[7] == en_q) else $error("control read wrong");
	chk_addr_read: assert property (reg_rd && reg_addr == brk_pkg::OFS_ADDR_HIGH
		|-> reg_rdata == bp_q[15:8]) else $error("address high read wrong");
	chk_wait_read: assert property (reg_rd && reg_addr == brk_pkg::OFS_WAIT_STATUS
		|-> {reg_rdata[7:2], reg_rdata[0]} == 7'h00) else $error("wait status spare bits set");
	chk_clear_gate: assert property (reg_rd && reg_addr == brk_pkg::OFS_FLAG_CLEAR
		|-> flag_clear_allow == (reg_rdata[7] || !brk_in_service)) else $error("clear gate wrong");
	cover property (hit_w && breakpoint_request);
	cover property (insn_start && breakpoint_request);
	cover property (reg_wr && reg_addr == brk_pkg::OFS_CTRL_STATUS && reg_wdata[6]);
endmodule : brk_checker

// ===== verif/test_brk_unit.sv
`timescale 1ns/1ps
// drives the integration logic from its processor side and its register bus
module test_brk_unit;
	logic clk, rst, mon, av, ist, ret, wt, take, irq, tk; // clock, reset, processor levels
	logic [15:0] ca, vec, vs; // processor address, vector out, vector sampled
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata, stat; // stat keeps the last word read from the controller
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs; // rs keeps the last read response
	logic [1:0] ws; // last write response
	logic [7:0] ir, os, b; // opcode out, opcode sampled, byte read back
	logic [15:0] offs [5]; // device registers for the reset sweep
	int n_errors, checked;
	brk_if brk_if_i ();
	brk_unit brk_unit_i (.CLK_IN(clk), .SYS_RST_IN(rst), .LINK(brk_if_i.dev));
	brk_sil brk_sil_i (.CLK_IN(clk), .SYS_RST_IN(rst), .LINK(brk_if_i.sil), .MONITOR_MODE_IN(mon),
		.CPU_ADDR_IN(ca), .CPU_ADDR_VALID_IN(av), .CPU_OPCODE_FETCH_IN(av),
		.CPU_INSN_START_IN(ist), .CPU_RETURN_IN(ret), .CPU_WAIT_IN(wt),
		.CPU_FETCH_OPCODE_IN(8'hA6), .CPU_IR_OPCODE_OUT(ir), .CPU_VECTOR_OUT(vec),
		.CPU_TAKE_BREAK_OUT(take), .IRQ_OUT(irq), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
		.AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hF), .WVALID_IN(wvalid),
		.WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
		.RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready));
	brk_checker brk_checker_i (.CLK_IN(clk), .SYS_RST_IN(rst), .cpu_addr(brk_if_i.cpu_addr),
		.addr_valid(brk_if_i.addr_valid), .insn_start(brk_if_i.insn_start),
		.reg_wr(brk_if_i.reg_wr), .reg_rd(brk_if_i.reg_rd), .reg_addr(brk_if_i.reg_addr),
		.reg_wdata(brk_if_i.reg_wdata), .reg_rdata(brk_if_i.reg_rdata),
		.brk_in_service(brk_if_i.brk_in_service), .flag_clear_allow(brk_if_i.flag_clear_allow),
		.breakpoint_request(brk_if_i.breakpoint_request));
	// free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// one comparison, counted
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// axi write: address and data offered together, each dropped once taken
	// handshakes are judged mid-cycle, so the edge that takes them is never raced
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_hit, w_hit, b_hit;
		@(posedge clk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		forever begin
			@(negedge clk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid;
			if (b_hit) ws = bresp;
			@(posedge clk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
			if (b_hit) break;
		end
		bready <= 1'b0;
	endtask : axi_wr
	// axi read: rready held until the data beat is seen
	task automatic axi_rd(input logic [3:0] a);
		logic ar_hit, r_hit;
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		forever begin
			@(negedge clk);
			ar_hit = arvalid && arready;
			r_hit = rvalid;
			if (r_hit) begin
				stat = rdata;
				rs = rresp;
			end
			@(posedge clk);
			if (ar_hit) arvalid <= 1'b0;
			if (r_hit) break;
		end
		rready <= 1'b0;
	endtask : axi_rd
	// device register access through the command word; the strobe follows in two edges
	task automatic dev_wr(input logic [15:0] a, input logic [7:0] d);
		axi_wr(brk_pkg::AX_CMD, {6'h00, 2'b11, d, a});
		repeat (2) @(posedge clk);
	endtask : dev_wr
	task automatic dev_rd(input logic [15:0] a);
		axi_wr(brk_pkg::AX_CMD, {6'h00, 2'b10, 8'h00, a});
		repeat (2) @(posedge clk);
		axi_rd(brk_pkg::AX_STATUS);
		b = stat[7:0];
	endtask : dev_rd
	// one processor cycle, outputs sampled mid-cycle where they have settled
	task automatic cyc(input logic [15:0] a, input logic s);
		@(posedge clk);
		ca <= a; av <= 1'b1; ist <= s;
		@(negedge clk);
		tk = take; vs = vec; os = ir;
		@(posedge clk);
		av <= 1'b0; ist <= 1'b0;
	endtask : cyc
	task automatic return_from_interrupt_instruction();
		@(posedge clk);
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
	endtask : return_from_interrupt_instruction
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("Error watchdog expected done seen hang");
		tally_and_finish();
	end
	initial begin
		{rst, mon, av, ist, ret, wt, awvalid, wvalid, bready, arvalid, rready} = 11'h400;
		ca = 16'h0000; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0000_0000;
		offs = '{16'hFE00, 16'hFE03, 16'hFE09, 16'hFE0A, 16'hFE0B};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// reset values of every device register, then an unmapped place on each bus
		foreach (offs[i]) begin
			dev_rd(offs[i]);
			chk("reset byte", 32'h0, b);
		end
		dev_rd(16'h0100);
		chk("unmapped hit", 32'h0, stat[8]);
		axi_rd(4'h2);
		chk("axi unmapped", brk_pkg::AXI_SLVERR, rs);
		axi_wr(4'h2, 32'h0);
		chk("axi write unmapped", brk_pkg::AXI_SLVERR, ws);
		// program 1234, enabled, and miss by one bit first
		dev_wr(brk_pkg::OFS_ADDR_HIGH, 8'h12);
		dev_wr(brk_pkg::OFS_ADDR_LOW, 8'h34);
		dev_wr(brk_pkg::OFS_CTRL_STATUS, 8'h80);
		dev_rd(brk_pkg::OFS_ADDR_LOW);
		chk("addr low", 32'h34, b);
		cyc(16'h1235, 1'b0);
		chk("near miss", 32'h0, tk);
		chk("plain opcode", 32'hA6, os);
		cyc(16'h1234, 1'b0); // opcode address targeted
		chk("match", 32'h1, tk);
		chk("swapped opcode", brk_pkg::OPC_SOFT_INT, os);
		chk("normal vector", 32'hFFFC, vs);
		dev_rd(brk_pkg::OFS_CTRL_STATUS);
		chk("active set", 32'hC0, b);
		chk("clear blocked", 32'h0, stat[10]);
		chk("irq masked", 32'h0, irq);
		dev_wr(brk_pkg::OFS_FLAG_CLEAR, 8'h80);
		dev_rd(brk_pkg::OFS_FLAG_CLEAR);
		chk("clear allowed", 32'h1, stat[10]);
		axi_wr(brk_pkg::AX_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h1, irq);
		axi_wr(brk_pkg::AX_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, irq);
		// clear active, return, same address again stays silent
		dev_wr(brk_pkg::OFS_CTRL_STATUS, 8'h80);
		dev_rd(brk_pkg::OFS_CTRL_STATUS);
		chk("active cleared", 32'h80, b);
		return_from_interrupt_instruction();
		cyc(16'h1234, 1'b0);
		chk("no rebreak", 32'h0, tk);
		dev_rd(brk_pkg::OFS_CTRL_STATUS);
		chk("service ended", 32'h0, stat[9]);
		axi_rd(brk_pkg::AX_IRQ_STAT);
		chk("return event", 32'h2, stat);
		// new address rearms, monitor vector
		mon <= 1'b1;
		dev_wr(brk_pkg::OFS_ADDR_LOW, 8'h40);
		cyc(16'h1240, 1'b0);
		chk("repeat break", 32'h1, tk);
		chk("monitor vector", 32'hFEFC, vs);
		// disabled comparator ignores a fresh match
		dev_wr(brk_pkg::OFS_CTRL_STATUS, 8'h00);
		return_from_interrupt_instruction();
		dev_wr(brk_pkg::OFS_ADDR_LOW, 8'h50);
		cyc(16'h1250, 1'b0);
		chk("disabled", 32'h0, tk);
		// software break waits for the next instruction start
		dev_wr(brk_pkg::OFS_CTRL_STATUS, 8'h40);
		cyc(16'h0000, 1'b0);
		chk("soft early", 32'h0, tk);
		cyc(16'h0000, 1'b1);
		chk("soft break", 32'h1, tk);
		return_from_interrupt_instruction();
		// match while waiting flags the wait exit, software zero clears it
		wt <= 1'b1;
		dev_wr(brk_pkg::OFS_CTRL_STATUS, 8'h80);
		dev_wr(brk_pkg::OFS_ADDR_LOW, 8'h60);
		cyc(16'h1260, 1'b0);
		wt <= 1'b0;
		dev_rd(brk_pkg::OFS_WAIT_STATUS);
		chk("wait exit", 32'h2, b);
		dev_wr(brk_pkg::OFS_WAIT_STATUS, 8'h00);
		dev_rd(brk_pkg::OFS_WAIT_STATUS);
		chk("wait cleared", 32'h0, b);
		tally_and_finish();
	end
endmodule : test_brk_unit
